// [pdswl_defs.vh]
// register map, field positions, reset values and encoding constants of the pulse duty link
`ifndef PDSWL_DEFS_VH
`define PDSWL_DEFS_VH
`define PDSWL_ADR_CTRL 6'h00
`define PDSWL_ADR_PERIOD 6'h01
`define PDSWL_ADR_DUTY 6'h02
`define PDSWL_ADR_SCALE 6'h03
`define PDSWL_ADR_TXDATA 6'h04
`define PDSWL_ADR_RXDATA 6'h05
`define PDSWL_ADR_RXHIGH 6'h06
`define PDSWL_ADR_RXPER 6'h07
`define PDSWL_ADR_OFFSET 6'h08
`define PDSWL_ADR_ISTAT 6'h09
`define PDSWL_ADR_IMASK 6'h0a
`define PDSWL_CTRL_TX_EN 0
`define PDSWL_CTRL_RX_EN 1
`define PDSWL_CTRL_AUTO 2
`define PDSWL_CTRL_DUTY_MODE 3
`define PDSWL_IRQ_TX_LOAD 0
`define PDSWL_IRQ_RX_WORD 1
`define PDSWL_IRQ_RX_OVR 2
`define PDSWL_PERIOD_RST 16'h00c8
`define PDSWL_SCALE_RST 8'h3c
`define PDSWL_DUTY_LO_Q16 17'h0199a
`define PDSWL_DUTY_SPAN_Q16 17'h0cccd
`define PDSWL_FRAC_BITS 8
`define PDSWL_DIV_STEPS 5'h10
`endif

// [pdswl_top.v]
// pulse duty single wire link: duty encoder with fine trailing edge, three-edge duty decoder, wishbone registers
//
// Our own choices: the register offsets and register access over Wishbone.
`include "pdswl_defs.vh"
module pdswl_top #(
  parameter RES_BITS = 11,
  parameter CNT_W = 16
) (
  input wire CLK_SYS,
  input wire RST,
  input wire WB_CYC_I,
  input wire WB_STB_I,
  input wire WB_WE_I,
  input wire [7:0] WB_ADR_I,
  input wire [3:0] WB_SEL_I,
  input wire [31:0] WB_DAT_I,
  output reg [31:0] WB_DAT_O,
  output reg WB_ACK_O,
  output wire IRQ,
  output reg PWM_OUT,
  output reg FINE_EDGE,
  output reg [7:0] FINE_STEPS,
  input wire SIG_IN
);

  // byte-lane merge of a write into a register
  function [31:0] lane_merge;
    input [31:0] old;
    input [31:0] wdat;
    input [3:0] sel;
    integer k;
    begin
      lane_merge = old;
      for (k = 0; k < 4; k = k + 1) begin
        if (sel[k]) begin
          lane_merge[k*8 +: 8] = wdat[k*8 +: 8];
        end
      end
    end
  endfunction

  // ---------------- registers ----------------
  reg [2:0] ctrl;
  reg [15:0] period_sh;
  reg [23:0] duty_sh;
  reg [7:0] step_scale;
  reg [RES_BITS-1:0] tx_data;
  reg [16:0] duty_offset;
  reg [2:0] irq_stat;
  reg [2:0] irq_mask;
  reg [RES_BITS-1:0] rx_data;
  reg [CNT_W-1:0] rx_high;
  reg [CNT_W-1:0] rx_per;

  wire bus_req = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
  wire bus_wr = bus_req & WB_WE_I;
  wire [5:0] word_adr = WB_ADR_I[7:2];
  wire [31:0] merged_ctrl = lane_merge({29'h0, ctrl}, WB_DAT_I, WB_SEL_I);
  wire [31:0] merged_per = lane_merge({16'h0, period_sh}, WB_DAT_I, WB_SEL_I);
  wire [31:0] merged_duty = lane_merge({8'h0, duty_sh}, WB_DAT_I, WB_SEL_I);
  wire [31:0] merged_scale = lane_merge({24'h0, step_scale}, WB_DAT_I, WB_SEL_I);
  wire [31:0] merged_off = lane_merge({15'h0, duty_offset}, WB_DAT_I, WB_SEL_I);
  wire [31:0] merged_mask = lane_merge({29'h0, irq_mask}, WB_DAT_I, WB_SEL_I);
  wire [31:0] merged_tx = lane_merge({{(32-RES_BITS){1'b0}}, tx_data}, WB_DAT_I, WB_SEL_I);
  wire [31:0] merged_clr = lane_merge(32'h0, WB_DAT_I, WB_SEL_I);

  // data word to duty in 16.8 counts: period * (0.1 + 0.8 * data / 2^res)
  wire [16:0] span_q16 = `PDSWL_DUTY_SPAN_Q16;
  wire [16+RES_BITS:0] span_prod = span_q16 * merged_tx[RES_BITS-1:0];
  wire [16:0] enc_duty_q16 = `PDSWL_DUTY_LO_Q16 + span_prod[16+RES_BITS:RES_BITS];
  wire [32:0] enc_prod = period_sh * enc_duty_q16;
  wire [23:0] enc_cmp = enc_prod[31:8];

  wire ev_tx_load;
  wire ev_rx_word;
  wire ev_rx_ovr;

  always @(posedge CLK_SYS) begin
    if (RST) begin
      ctrl <= 3'h0;
      period_sh <= `PDSWL_PERIOD_RST;
      duty_sh <= 24'h0;
      step_scale <= `PDSWL_SCALE_RST;
      tx_data <= {RES_BITS{1'b0}};
      duty_offset <= 17'h0;
      irq_mask <= 3'h0;
      irq_stat <= 3'h0;
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= 32'h0;
    end else begin
      WB_ACK_O <= bus_req;
      if (bus_wr) begin
        case (word_adr)
          `PDSWL_ADR_CTRL: ctrl <= merged_ctrl[2:0];
          `PDSWL_ADR_PERIOD: period_sh <= merged_per[15:0];
          `PDSWL_ADR_DUTY: duty_sh <= merged_duty[23:0];
          `PDSWL_ADR_SCALE: step_scale <= merged_scale[7:0];
          `PDSWL_ADR_OFFSET: duty_offset <= merged_off[16:0];
          `PDSWL_ADR_IMASK: irq_mask <= merged_mask[2:0];
          `PDSWL_ADR_TXDATA: begin
            tx_data <= merged_tx[RES_BITS-1:0];
            duty_sh <= enc_cmp;
          end
          default: ;
        endcase
      end
      // set wins over write-one-to-clear
      irq_stat <= (irq_stat & ~((bus_wr && word_adr == `PDSWL_ADR_ISTAT) ? merged_clr[2:0] : 3'h0))
                  | {ev_rx_ovr, ev_rx_word, ev_tx_load};
      if (bus_req && !WB_WE_I) begin
        case (word_adr)
          `PDSWL_ADR_CTRL: WB_DAT_O <= {28'h0, 1'b1, ctrl};
          `PDSWL_ADR_PERIOD: WB_DAT_O <= {16'h0, period_sh};
          `PDSWL_ADR_DUTY: WB_DAT_O <= {8'h0, duty_sh};
          `PDSWL_ADR_SCALE: WB_DAT_O <= {24'h0, step_scale};
          `PDSWL_ADR_TXDATA: WB_DAT_O <= {{(32-RES_BITS){1'b0}}, tx_data};
          `PDSWL_ADR_RXDATA: WB_DAT_O <= {{(32-RES_BITS){1'b0}}, rx_data};
          `PDSWL_ADR_RXHIGH: WB_DAT_O <= {{(32-CNT_W){1'b0}}, rx_high};
          `PDSWL_ADR_RXPER: WB_DAT_O <= {{(32-CNT_W){1'b0}}, rx_per};
          `PDSWL_ADR_OFFSET: WB_DAT_O <= {15'h0, duty_offset};
          `PDSWL_ADR_ISTAT: WB_DAT_O <= {29'h0, irq_stat};
          `PDSWL_ADR_IMASK: WB_DAT_O <= {29'h0, irq_mask};
          default: WB_DAT_O <= 32'h0;
        endcase
      end
    end
  end

  assign IRQ = |(irq_stat & irq_mask);

  // ---------------- encoder ----------------
  reg [15:0] period_act;
  reg [23:0] duty_act;
  reg [15:0] pcnt;
  wire tx_en = ctrl[`PDSWL_CTRL_TX_EN];
  wire auto_conv = ctrl[`PDSWL_CTRL_AUTO];
  wire period_end = (pcnt >= period_act - 16'h0001) || (period_act == 16'h0000);
  wire [15:0] cmp_int = duty_act[23:8];
  wire [7:0] cmp_frac = duty_act[7:0];
  wire [15:0] frac_prod = cmp_frac * step_scale;
  // rounded fraction times scale; without auto conversion the fraction is a raw step count
  wire [8:0] auto_steps = frac_prod[15:7] + 9'h001;
  wire [7:0] raw_steps = (cmp_frac > step_scale) ? step_scale : cmp_frac;
  wire [7:0] next_steps = auto_conv ? auto_steps[8:1] : raw_steps;

  assign ev_tx_load = tx_en & period_end;

  always @(posedge CLK_SYS) begin
    if (RST) begin
      period_act <= `PDSWL_PERIOD_RST;
      duty_act <= 24'h0;
      pcnt <= 16'h0;
      PWM_OUT <= 1'b0;
      FINE_EDGE <= 1'b0;
      FINE_STEPS <= 8'h0;
    end else if (!tx_en) begin
      pcnt <= 16'h0;
      period_act <= period_sh;
      duty_act <= duty_sh;
      PWM_OUT <= 1'b0;
      FINE_EDGE <= 1'b0;
      FINE_STEPS <= 8'h0;
    end else begin
      if (period_end) begin
        pcnt <= 16'h0;
        period_act <= period_sh;
        duty_act <= duty_sh;
      end else begin
        pcnt <= pcnt + 16'h0001;
      end
      // leading edge fixed at count zero, coarse high until the compare count
      PWM_OUT <= (pcnt < cmp_int) || (pcnt == cmp_int && next_steps != 8'h0);
      // in the last high cycle the external delay line trims the fall by this many fine steps
      FINE_EDGE <= (pcnt == cmp_int) && (next_steps != 8'h0);
      FINE_STEPS <= (pcnt == cmp_int) ? next_steps : 8'h0;
    end
  end

  // ---------------- decoder ----------------
  localparam CAP_RISE1 = 2'h0;
  localparam CAP_FALL = 2'h1;
  localparam CAP_RISE2 = 2'h2;

  reg [CNT_W-1:0] free_cnt;
  reg sig_d;
  reg [1:0] cap_state;
  reg [CNT_W-1:0] cap1;
  reg [CNT_W-1:0] cap2;
  reg div_busy;
  reg [4:0] div_cnt;
  reg [CNT_W:0] div_rem;
  reg [15:0] div_q;
  reg [CNT_W-1:0] div_den;
  reg div_done;
  wire rx_en = ctrl[`PDSWL_CTRL_RX_EN];
  wire rise = SIG_IN & ~sig_d;
  wire fall = ~SIG_IN & sig_d;
  wire third = rx_en && cap_state == CAP_RISE2 && rise;
  // relative counts wrap with the counter
  wire [CNT_W-1:0] rel_high = cap2 - cap1;
  wire [CNT_W-1:0] rel_per = free_cnt - cap1;
  wire [CNT_W:0] shifted_rem = {div_rem[CNT_W-1:0], 1'b0};
  wire rem_ge = shifted_rem >= {1'b0, div_den};

  assign ev_rx_ovr = third & div_busy;
  assign ev_rx_word = div_done;

  always @(posedge CLK_SYS) begin
    if (RST) begin
      free_cnt <= {CNT_W{1'b0}};
      sig_d <= 1'b0;
      cap_state <= CAP_RISE1;
      cap1 <= {CNT_W{1'b0}};
      cap2 <= {CNT_W{1'b0}};
      rx_high <= {CNT_W{1'b0}};
      rx_per <= {CNT_W{1'b0}};
    end else begin
      free_cnt <= free_cnt + {{(CNT_W-1){1'b0}}, 1'b1};
      sig_d <= SIG_IN;
      if (!rx_en) begin
        cap_state <= CAP_RISE1;
      end else begin
        case (cap_state)
          CAP_RISE1: if (rise) begin
            cap1 <= free_cnt;
            cap_state <= CAP_FALL;
          end
          CAP_FALL: if (fall) begin
            cap2 <= free_cnt;
            cap_state <= CAP_RISE2;
          end
          CAP_RISE2: if (rise) begin
            cap1 <= free_cnt;
            rx_high <= rel_high;
            rx_per <= rel_per;
            cap_state <= CAP_FALL;
          end
          default: cap_state <= CAP_RISE1;
        endcase
      end
    end
  end

  // duty = high / period in Q16 by restoring division, counts only, no time units
  always @(posedge CLK_SYS) begin
    if (RST) begin
      div_busy <= 1'b0;
      div_cnt <= 5'h0;
      div_rem <= {(CNT_W+1){1'b0}};
      div_q <= 16'h0;
      div_den <= {CNT_W{1'b0}};
      div_done <= 1'b0;
    end else begin
      div_done <= 1'b0;
      if (third && !div_busy) begin
        div_busy <= 1'b1;
        div_cnt <= 5'h0;
        div_rem <= {1'b0, rel_high};
        div_den <= rel_per;
        div_q <= 16'h0;
      end else if (div_busy) begin
        div_rem <= rem_ge ? shifted_rem - {1'b0, div_den} : shifted_rem;
        div_q <= {div_q[14:0], rem_ge};
        div_cnt <= div_cnt + 5'h01;
        if (div_cnt == `PDSWL_DIV_STEPS - 5'h01) begin
          div_busy <= 1'b0;
          div_done <= 1'b1;
        end
      end
    end
  end

  // (duty - offset - 0.1) * 1.25, scaled to the word width and clamped
  wire signed [18:0] duty_adj = $signed({3'b000, div_q}) - $signed({2'b00, duty_offset})
                                - $signed({2'b00, `PDSWL_DUTY_LO_Q16});
  wire signed [21:0] norm_q16 = (duty_adj * $signed(22'sd5)) >>> 2;
  wire [21:0] norm_bits = norm_q16;
  wire [RES_BITS-1:0] word_max = {RES_BITS{1'b1}};
  wire norm_over = norm_bits[20:16] != 5'h0;
  wire [RES_BITS:0] norm_round = {1'b0, norm_bits[15:16-RES_BITS]} + {{RES_BITS{1'b0}}, norm_bits[15-RES_BITS]};

  always @(posedge CLK_SYS) begin
    if (RST) begin
      rx_data <= {RES_BITS{1'b0}};
    end else if (div_done) begin
      if (norm_q16 < 0) begin
        rx_data <= {RES_BITS{1'b0}};
      end else if (norm_over || norm_round[RES_BITS]) begin
        rx_data <= word_max;
      end else begin
        rx_data <= norm_round[RES_BITS-1:0];
      end
    end
  end

endmodule // pdswl_top

// [pdswl_chk_properties.sv]
// port relation checker for the pulse duty link top
module pdswl_chk (
  input wire CLK_SYS,
  input wire RST,
  input wire WB_CYC_I,
  input wire WB_STB_I,
  input wire WB_WE_I,
  input wire [31:0] WB_DAT_O,
  input wire WB_ACK_O,
  input wire IRQ,
  input wire PWM_OUT,
  input wire FINE_EDGE,
  input wire [7:0] FINE_STEPS
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  property p_ack_next;
    WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O;
  endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack late");
  property p_ack_pulse;
    WB_ACK_O |=> !WB_ACK_O;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  property p_no_req;
    !(WB_CYC_I && WB_STB_I) |=> !WB_ACK_O;
  endproperty
  a_no_req: assert property (p_no_req) else $error("ack without request");
  property p_dat_hold;
    $changed(WB_DAT_O) |-> WB_ACK_O && !WB_WE_I;
  endproperty
  a_dat_hold: assert property (p_dat_hold) else $error("read data moved");
  property p_steps_zero;
    !FINE_EDGE |-> FINE_STEPS == 8'h00;
  endproperty
  a_steps_zero: assert property (p_steps_zero) else $error("steps without trim");
  property p_fine_in_pulse;
    FINE_EDGE |-> PWM_OUT;
  endproperty
  a_fine_in_pulse: assert property (p_fine_in_pulse) else $error("trim outside pulse");
  property p_trail;
    $fell(FINE_EDGE) |-> $fell(PWM_OUT);
  endproperty
  a_trail: assert property (p_trail) else $error("trim not at trailing edge");
  property p_rst_clear;
    $fell(RST) |-> !WB_ACK_O && !IRQ && !PWM_OUT && !FINE_EDGE;
  endproperty
  a_rst_clear: assert property (p_rst_clear) else $error("outputs not cleared");
endmodule // pdswl_chk
bind pdswl_top pdswl_chk u_pdswl_chk (.CLK_SYS, .RST, .WB_CYC_I, .WB_STB_I, .WB_WE_I, .WB_DAT_O, .WB_ACK_O,
  .IRQ, .PWM_OUT, .FINE_EDGE, .FINE_STEPS);

// [pdswl_src.sv]
// pulse source standing in for the remote duty encoder
module pdswl_src (
  input wire clk,
  input wire en,
  input wire [15:0] high,
  input wire [15:0] per,
  output reg sig
);
  timeunit 1ns;
  timeprecision 100ps;
  reg [15:0] cnt = 16'h0000;
  // leading edge at count zero, width follows high
  always @(posedge clk) begin
    cnt <= (!en || cnt >= per - 16'h0001) ? 16'h0000 : cnt + 16'h0001;
    sig <= en && cnt < high;
  end
endmodule // pdswl_src

// [testbench.sv]
// register, pwm and decoder tests of the pulse duty link
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg cyc = 1'b0;
  reg we = 1'b0;
  reg [7:0] adr = 8'h00;
  reg [31:0] wdat = 32'h0;
  reg sen = 1'b0;
  reg [15:0] sh = 16'h0;
  reg [15:0] sp = 16'h0;
  wire [31:0] rdat;
  wire ack, irq, pwm, fe, sig;
  wire [7:0] fs;
  reg [31:0] rd;
  integer fail_count = 0;
  integer comparisons = 0;
  integer cy = 0;
  integer t0;
  always #12.5 clk = ~clk;
  always @(posedge clk) cy <= cy + 1;
  pdswl_top #(.RES_BITS(11), .CNT_W(16)) u_pdswl_top (.CLK_SYS(clk), .RST(rst), .WB_CYC_I(cyc), .WB_STB_I(cyc),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hf), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
    .IRQ(irq), .PWM_OUT(pwm), .FINE_EDGE(fe), .FINE_STEPS(fs), .SIG_IN(sig));
  pdswl_src u_pdswl_src (.clk(clk), .en(sen), .high(sh), .per(sp), .sig(sig));
  task results;
    begin
      $display("checks %0d errors %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask
  task chk(input [8*6:1] nm, input [31:0] e, input [31:0] g);
    begin
      comparisons = comparisons + 1;
      if (g !== e) begin
        fail_count = fail_count + 1;
        $display("[ERR] %0s exp %h got %h", nm, e, g);
      end
    end
  endtask
  task tmo(input integer i);
    begin
      if (i >= 3000) begin
        chk("wait", 0, 1);
        results;
      end
    end
  endtask
  task wb(input reg w, input [7:0] a, input [31:0] d);
    integer i;
    begin
      @(posedge clk);
      cyc <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      i = 0;
      do begin
        @(posedge clk);
        i = i + 1;
      end while (ack !== 1'b1 && i < 3000);
      rd = rdat;
      cyc <= 1'b0;
      tmo(i);
    end
  endtask
  task rc(input [7:0] a, input [31:0] e, input [8*6:1] nm);
    begin
      wb(1'b0, a, 32'h0);
      chk(nm, e, rd);
    end
  endtask
  // waits for pwm (0), trim flag (1) or irq (2) to reach v
  task ww(input integer s, input reg v);
    integer i;
    begin
      i = 0;
      do begin
        @(posedge clk);
        i = i + 1;
      end while ((s == 0 ? pwm : s == 1 ? fe : irq) !== v && i < 3000);
      tmo(i);
    end
  endtask
  task rx(input [15:0] h, input [31:0] e, input [8*6:1] nm);
    integer k;
    begin
      sh <= h;
      for (k = 0; k < 3; k = k + 1) begin
        wb(1'b1, 8'h24, 32'h7);
        ww(2, 1'b1);
      end
      @(posedge clk);
      rc(8'h14, e, nm);
    end
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rc(8'h00, 32'h8, "ctrl");
    rc(8'h04, 32'hc8, "period");
    rc(8'h0c, 32'h3c, "scale");
    rc(8'h3c, 32'h0, "unmap");
    wb(1'b1, 8'h04, 32'h64);
    wb(1'b1, 8'h10, 32'h0);
    rc(8'h08, 32'ha00, "dmin");
    wb(1'b1, 8'h10, 32'h400);
    rc(8'h08, 32'h3200, "dmid");
    wb(1'b1, 8'h28, 32'h1);
    wb(1'b1, 8'h00, 32'h1);
    ww(0, 1'b0);
    ww(0, 1'b1);
    t0 = cy;
    wb(1'b1, 8'h08, 32'ha00);
    ww(0, 1'b0);
    chk("high1", 50, cy - t0);
    ww(0, 1'b1);
    chk("per", 100, cy - t0);
    t0 = cy;
    ww(0, 1'b0);
    chk("high2", 10, cy - t0);
    chk("irqon", 1, irq);
    wb(1'b1, 8'h24, 32'h1);
    @(posedge clk);
    chk("irqclr", 0, irq);
    wb(1'b1, 8'h28, 32'h0);
    repeat (110) @(posedge clk);
    chk("irqmsk", 0, irq);
    rc(8'h24, 32'h1, "stat");
    wb(1'b1, 8'h00, 32'h5);
    wb(1'b1, 8'h08, 32'ha80);
    ww(1, 1'b1);
    chk("fauto", 32'h1e, fs);
    wb(1'b1, 8'h00, 32'h1);
    ww(1, 1'b0);
    ww(1, 1'b1);
    ww(1, 1'b0);
    ww(1, 1'b1);
    chk("fman", 32'h3c, fs);
    wb(1'b1, 8'h28, 32'h2);
    wb(1'b1, 8'h00, 32'h2);
    sp <= 16'd100;
    sen <= 1'b1;
    rx(16'd50, 32'h400, "rxmid");
    rc(8'h18, 32'd50, "rxhigh");
    rc(8'h1c, 32'd100, "rxper");
    rx(16'd10, 32'h0, "rxmin");
    rx(16'd90, 32'h7ff, "rxmax");
    wb(1'b1, 8'h20, 32'h199a);
    rx(16'd50, 32'h300, "rxofs");
    // pulses shorter than the divider run: every other word is dropped and flagged
    sp <= 16'd10;
    sh <= 16'd5;
    wb(1'b1, 8'h24, 32'h7);
    repeat (100) @(posedge clk);
    rc(8'h24, 32'h6, "ovr");
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    chk("irqrst", 0, irq);
    rc(8'h20, 32'h0, "ofsrst");
    results;
  end
endmodule // testbench
